/* File: verilog/fast_link_drop_config.sv */
`timescale 1ns/10ps
`include "drop_cfg_defines.svh"

module fast_link_drop_config #(
    parameter int MS_CYCLES = `TICK_CYCLES
) (
    input  wire logic                      aclk,           // 25 MHz clock
    input  wire logic                      aresetn,        // sync reset
    input  wire logic [11:0]               awaddr,         // write address
    input  wire logic                      awvalid,        // aw valid
    output logic                           awready,        // aw ready
    input  wire logic [31:0]               wdata,          // write data
    input  wire logic [3:0]                wstrb,          // byte enables
    input  wire logic                      wvalid,         // w valid
    output logic                           wready,         // w ready
    output logic [1:0]                     bresp,          // write answer
    output logic                           bvalid,         // b valid
    input  wire logic                      bready,         // b ready
    input  wire logic [11:0]               araddr,         // read address
    input  wire logic                      arvalid,        // ar valid
    output logic                           arready,        // ar ready
    output logic [31:0]                    rdata,          // read data
    output logic [1:0]                     rresp,          // read answer
    output logic                           rvalid,         // r valid
    input  wire logic                      rready,         // r ready
    input  wire drop_cfg_pkg::src_vec_t    drop_criteria,  // source fired
    input  wire drop_cfg_pkg::energy_acc_t energy_accum,   // energy level
    input  wire logic                      signal_detect,  // rx signal seen
    input  wire logic [1:0]                strap_rx_mode,  // rx ctrl strap
    input  wire logic                      strap_qd_en,    // quick drop strap
    input  wire logic                      strap_mirror,   // mirror strap
    output logic                           robust_xover_en,  // robust mode
    output logic [3:0]                     xover_timer_code, // timer code
    output logic                           xover_timer_tick, // period pulse
    output logic                           partner_drop,   // force drop
    output logic                           quick_drop_link,// drop pulse
    output logic                           energy_low,     // energy lost
    output logic                           internal_test_mode_one, // test
    output logic                           mirror_en,      // pin mirror
    output logic                           irq             // interrupt
);
    import drop_cfg_pkg::*;

    localparam top_state_t RST_STATE = '{
        wstate:   WS_IDLE,
        rstate:   RS_IDLE,
        awready:  1'b1,
        wready:   1'b1,
        arready:  1'b1,
        tmr_hi:   `TMR_RES_RST,
        tmr_code: `TMR_CODE_RST,
        thr_hi:   `THR_RES_RST,
        thr_mid:  `THR_RES_RST,
        thr:      `THR_RST,
        default:  '0
    };

    top_state_t  st_r;
    top_state_t  st_nxt;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic [6:0]  ar_idx;
    logic        do_write;
    logic [15:0] wr_word;
    logic [4:0]  int_clr;
    logic        rd_clr;
    logic        energy_low_now;
    src_vec_t    crit;
    src_vec_t    cause;
    logic        tmr_tick;

    function automatic logic [6:0] addr_idx(input logic [11:0] a);
        addr_idx = (a[11:9] == 3'h0) ? a[8:2] : `IDX_NONE;
    endfunction

    function automatic logic mapped(input logic [6:0] idx);
        case (idx)
            `IDX_XOVER_TMR, `IDX_DROP_CFG, `IDX_DROP_THR, `IDX_CFG_FOUR,
            `IDX_XOVER_CTRL, `IDX_STRAP_STS, `IDX_INT_STS, `IDX_INT_EN,
            `IDX_INT_CLR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // readback also serves as the old value for byte-lane merges
    function automatic logic [15:0] reg_word(input top_state_t s,
                                             input logic [6:0] idx);
        case (idx)
            `IDX_XOVER_TMR: reg_word = {s.tmr_hi, s.tmr_code};
            `IDX_DROP_CFG: reg_word = {s.force_drop, s.qd_en, 1'b0,
                                       s.qd_sts, 3'h0, s.src_en};
            `IDX_DROP_THR: reg_word = {5'h0, s.thr_hi, 1'b0, s.thr_mid,
                                       1'b0, s.thr};
            `IDX_CFG_FOUR: reg_word = `CONFIG_FOUR_FIXED
                                    | {7'h0, s.config_four_b8, s.itm, 6'h0,
                                       s.mirror};
            `IDX_XOVER_CTRL: reg_word = {6'h0, s.robust_en, 9'h0};
            `IDX_STRAP_STS: reg_word = {7'h0, ~s.strap_tm_req, 8'h0};
            `IDX_INT_STS: reg_word = {11'h0, s.int_sts};
            `IDX_INT_EN: reg_word = {11'h0, s.int_en};
            default: reg_word = 16'h0;
        endcase
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  strb);
        merge = {strb[1] ? nw[15:8] : old[15:8],
                 strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.link_drop = 1'b0;
        aw_hs = awvalid && st_r.awready;
        w_hs = wvalid && st_r.wready;
        ar_hs = arvalid && st_r.arready;
        ar_idx = addr_idx(araddr);
        do_write = 1'b0;
        int_clr = 5'h0;
        wr_word = merge(reg_word(st_r, st_r.widx), st_r.wdata, st_r.wstrb);

        // address and data may arrive in either order
        if (aw_hs) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.widx = addr_idx(awaddr);
        end
        if (w_hs) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = wdata[15:0];
            st_nxt.wstrb = wstrb[1:0];
        end

        case (st_r.wstate)
            WS_IDLE: begin
                if (st_r.aw_have && st_r.w_have) begin
                    do_write = 1'b1;
                    st_nxt.aw_have = 1'b0;
                    st_nxt.w_have = 1'b0;
                    st_nxt.bvalid = 1'b1;
                    st_nxt.bresp = mapped(st_r.widx) ? `RESP_OKAY
                                                     : `RESP_SLVERR;
                    st_nxt.wstate = WS_RESP;
                end
            end
            WS_RESP: begin
                if (bready) begin
                    st_nxt.bvalid = 1'b0;
                    st_nxt.wstate = WS_IDLE;
                end
            end
            default: st_nxt.wstate = WS_IDLE;
        endcase
        st_nxt.awready = (st_nxt.wstate == WS_IDLE) && !st_nxt.aw_have;
        st_nxt.wready = (st_nxt.wstate == WS_IDLE) && !st_nxt.w_have;

        if (do_write) begin
            case (st_r.widx)
                `IDX_XOVER_TMR: begin
                    st_nxt.tmr_hi = wr_word[15:4];
                    st_nxt.tmr_code = wr_word[3:0];
                end
                `IDX_DROP_CFG: begin
                    st_nxt.force_drop = wr_word[`BIT_FORCE_DROP];
                    st_nxt.qd_en = wr_word[`BIT_QD_EN];
                    st_nxt.src_en = wr_word[4:0];
                end
                `IDX_DROP_THR: begin
                    st_nxt.thr_hi = wr_word[10:8];
                    st_nxt.thr_mid = wr_word[6:4];
                    st_nxt.thr = wr_word[2:0];
                end
                `IDX_CFG_FOUR: begin
                    st_nxt.config_four_b8 = wr_word[`BIT_CONFIG_FOUR_RES];
                    st_nxt.itm = wr_word[`BIT_ITM];
                    st_nxt.mirror = wr_word[`BIT_MIRROR];
                end
                `IDX_XOVER_CTRL: st_nxt.robust_en = wr_word[`BIT_ROBUST_EN];
                `IDX_INT_EN: st_nxt.int_en = wr_word[4:0];
                `IDX_INT_CLR: int_clr = wr_word[4:0];
                default: ;
            endcase
        end

        case (st_r.rstate)
            RS_IDLE: begin
                if (ar_hs) begin
                    st_nxt.rvalid = 1'b1;
                    st_nxt.arready = 1'b0;
                    st_nxt.rdata = {16'h0, reg_word(st_r, ar_idx)};
                    st_nxt.rresp = mapped(ar_idx) ? `RESP_OKAY
                                                  : `RESP_SLVERR;
                    st_nxt.rstate = RS_RESP;
                end
            end
            RS_RESP: begin
                if (rready) begin
                    st_nxt.rvalid = 1'b0;
                    st_nxt.arready = 1'b1;
                    st_nxt.rstate = RS_IDLE;
                end
            end
            default: st_nxt.rstate = RS_IDLE;
        endcase

        energy_low_now = energy_accum < {5'h0, st_r.thr};
        crit = {drop_criteria[4:1], drop_criteria[0] | energy_low_now};
        // only enabled sources while feature on
        cause = st_r.qd_en ? (crit & st_r.src_en) : 5'h0;
        rd_clr = ar_hs && (ar_idx == `IDX_DROP_CFG);
        st_nxt.qd_sts = (rd_clr ? 5'h0 : st_r.qd_sts) | cause;
        st_nxt.int_sts = (st_r.int_sts & ~int_clr) | cause;
        st_nxt.irq = |(st_nxt.int_sts & st_nxt.int_en);
        st_nxt.link_drop = |cause;
        st_nxt.energy_low = energy_low_now;
        st_nxt.partner_drop = st_r.force_drop && !signal_detect;

        // straps sampled once, on the first edge after reset release
        if (!st_r.straps_done) begin
            st_nxt.straps_done = 1'b1;
            st_nxt.strap_tm_req = (strap_rx_mode == `RXMODE_ONE)
                               || (strap_rx_mode == `RXMODE_TWO);
            st_nxt.itm = st_nxt.strap_tm_req;
            st_nxt.mirror = strap_mirror;
            if (strap_qd_en) begin
                st_nxt.qd_en = 1'b1;
                st_nxt.thr = `THR_STRAP;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= RST_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // timer runs from the 4-bit code
    crossover_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (st_r.robust_en),
        .code    (st_r.tmr_code),
        .tick    (tmr_tick)
    );

    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bresp = st_r.bresp;
    assign bvalid = st_r.bvalid;
    assign arready = st_r.arready;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign rvalid = st_r.rvalid;
    assign robust_xover_en = st_r.robust_en;
    assign xover_timer_code = st_r.tmr_code;
    assign xover_timer_tick = tmr_tick;
    assign partner_drop = st_r.partner_drop;
    assign quick_drop_link = st_r.link_drop;
    assign energy_low = st_r.energy_low;
    assign internal_test_mode_one = st_r.itm;
    assign mirror_en = st_r.mirror;
    assign irq = st_r.irq;

    status_latch_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (|cause) |=> ((st_r.qd_sts & $past(cause)) == $past(cause)))
        else $error("quick drop status missed a firing source");

    status_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (rd_clr && cause == 5'h0) |=> (st_r.qd_sts == 5'h0))
        else $error("status read did not clear quick drop status");

    source_gate_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st_r.src_en == 5'h0 || !st_r.qd_en) |=> !quick_drop_link)
        else $error("link dropped with no source enabled");

    drop_pulse_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (|cause) |=> quick_drop_link)
        else $error("enabled criterion did not drop the link");

    partner_drop_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st_r.force_drop && !signal_detect) |=> partner_drop)
        else $error("partner drop not requested on signal loss");

    energy_thr_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (energy_accum < {5'h0, st_r.thr}) |=> energy_low)
        else $error("energy loss missed below threshold");

    strap_flag_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(st_r.straps_done)
        |-> (reg_word(st_r, `IDX_STRAP_STS) == 16'h0100)
            != ($past(strap_rx_mode) == `RXMODE_ONE
                || $past(strap_rx_mode) == `RXMODE_TWO))
        else $error("strap test request flag wrong");

    irq_level_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (|(st_r.int_sts & st_r.int_en)) |-> irq)
        else $error("interrupt low with enabled status set");

    read_answer_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ar_hs |=> rvalid && !arready)
        else $error("read answer not one cycle after address");

    bvalid_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (bvalid && !bready) |=> bvalid && $stable(bresp))
        else $error("write answer dropped before taken");

endmodule

/* File: verilog/drop_cfg_defines.svh */
`ifndef DROP_CFG_DEFINES_SVH
`define DROP_CFG_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_XOVER_TMR   7'h2c
`define IDX_DROP_CFG    7'h2d
`define IDX_DROP_THR    7'h2e
`define IDX_CFG_FOUR    7'h31
`define IDX_XOVER_CTRL  7'h40
`define IDX_STRAP_STS   7'h6f
`define IDX_INT_STS     7'h70
`define IDX_INT_EN      7'h71
`define IDX_INT_CLR     7'h72
`define IDX_NONE        7'h7f

// field positions
`define BIT_FORCE_DROP  15
`define BIT_QD_EN       14
`define BIT_ROBUST_EN   9
`define BIT_STRAP_TM    8
`define BIT_CONFIG_FOUR_RES    8
`define BIT_ITM         7
`define BIT_MIRROR      0

// reset, strap-load and fixed readback values
`define TMR_CODE_RST    4'hf
`define TMR_RES_RST     12'h141
`define THR_RST         3'h1
`define THR_STRAP       3'h2
`define THR_RES_RST     3'h2
`define CONFIG_FOUR_FIXED      16'h1010

// strap encodings and bus answers
`define RXMODE_ONE      2'h1
`define RXMODE_TWO      2'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// timing
`define CLK_FREQ_KHZ    25000
`define TICK_TIME_MS    1
`define TICK_CYCLES     (`CLK_FREQ_KHZ * `TICK_TIME_MS)
`define XOVER_STEP_MS   32

`endif

/* File: verilog/drop_cfg_pkg.sv */
package drop_cfg_pkg;

    typedef logic [4:0]  src_vec_t;
    typedef logic [3:0]  xover_code_t;
    typedef logic [7:0]  energy_acc_t;

    typedef enum logic { WS_IDLE = 1'b0, WS_RESP = 1'b1 } wstate_t;
    typedef enum logic { RS_IDLE = 1'b0, RS_RESP = 1'b1 } rstate_t;

    typedef struct packed {
        logic [19:0] ms_cnt;
        logic [9:0]  per_cnt;
        logic        tick;
    } tmr_state_t;

    typedef struct packed {
        wstate_t     wstate;
        rstate_t     rstate;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_have;
        logic        w_have;
        logic [6:0]  widx;
        logic [15:0] wdata;
        logic [1:0]  wstrb;
        logic [11:0] tmr_hi;
        logic [3:0]  tmr_code;
        logic        force_drop;
        logic        qd_en;
        logic [4:0]  qd_sts;
        logic [4:0]  src_en;
        logic [2:0]  thr_hi;
        logic [2:0]  thr_mid;
        logic [2:0]  thr;
        logic        config_four_b8;
        logic        itm;
        logic        mirror;
        logic        robust_en;
        logic        straps_done;
        logic        strap_tm_req;
        logic [4:0]  int_sts;
        logic [4:0]  int_en;
        logic        irq;
        logic        partner_drop;
        logic        link_drop;
        logic        energy_low;
    } top_state_t;

endpackage

/* File: verilog/crossover_timer.sv */
`timescale 1ns/10ps
`include "drop_cfg_defines.svh"

module crossover_timer #(
    parameter int MS_CYCLES = `TICK_CYCLES
) (
    input  wire logic                      aclk,    // system clock
    input  wire logic                      aresetn, // sync reset, low
    input  wire logic                      enable,  // robust mode on
    input  wire drop_cfg_pkg::xover_code_t code,    // period code
    output logic                           tick     // period expiry pulse
);
    import drop_cfg_pkg::*;

    tmr_state_t  st_r;
    tmr_state_t  st_nxt;
    logic [9:0]  last_ms;

    // period is (code + 1) steps of 32 ms
    assign last_ms = 10'({1'b0, code} + 5'd1) * 10'(`XOVER_STEP_MS) - 10'd1;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!enable) begin
            st_nxt.ms_cnt = 20'h0;
            st_nxt.per_cnt = 10'h0;
        end else if (st_r.ms_cnt == 20'(MS_CYCLES - 1)) begin
            st_nxt.ms_cnt = 20'h0;
            if (st_r.per_cnt >= last_ms) begin
                st_nxt.per_cnt = 10'h0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.per_cnt = st_r.per_cnt + 10'd1;
            end
        end else begin
            st_nxt.ms_cnt = st_r.ms_cnt + 20'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    tick_needs_en_a: assert property (
        @(posedge aclk) disable iff (!aresetn) tick |-> $past(enable))
        else $error("crossover tick while robust mode off");

    tick_spacing_a: assert property (
        @(posedge aclk) disable iff (!aresetn) tick |=> !tick [*8])
        else $error("crossover ticks closer than one period");

endmodule

/* File: tb/link_partner.sv */
`timescale 1ns/10ps

module link_partner
    import drop_cfg_pkg::*;
(
    input  wire logic                      aclk,      // clock
    input  wire drop_cfg_pkg::src_vec_t    crit_cmd,  // faults to show
    input  wire drop_cfg_pkg::energy_acc_t level_cmd, // energy to show
    input  wire logic                      tx_cmd,    // partner sending
    output drop_cfg_pkg::src_vec_t         crit,      // fault detectors
    output drop_cfg_pkg::energy_acc_t      level,     // energy detector
    output logic                           sig        // signal present
);
    initial begin
        crit = '0;
        level = 8'hff;
        sig = 1'b1;
    end
    // one cycle of line delay, as a real receive path has
    always @(posedge aclk) begin
        crit  <= crit_cmd;
        level <= level_cmd;
        sig   <= tx_cmd;
    end
endmodule

/* File: tb/fast_link_drop_config_tb.sv */
`timescale 1ns/10ps
`include "drop_cfg_defines.svh"
`define CHK(nm, e, s) \
    begin \
        num_checks++; \
        if ((s) !== (e)) begin \
            errors++; \
            $display("unexpected %s exp %0h got %0h", nm, e, s); \
        end \
    end

module fast_link_drop_config_tb;
    import drop_cfg_pkg::*;
    localparam int MSC = 2;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [1:0]  strap_rx_mode = 2'h1;
    logic        strap_qd_en = 1'b0;
    logic        strap_mirror = 1'b1;
    src_vec_t    crit_cmd = '0;
    energy_acc_t level_cmd = 8'hff;
    logic        tx_cmd = 1'b1;
    src_vec_t    drop_criteria;
    energy_acc_t energy_accum;
    logic        signal_detect, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, d;
    logic [3:0]  xover_timer_code;
    logic        robust_xover_en, xover_timer_tick, partner_drop;
    logic        quick_drop_link, energy_low, internal_test_mode_one;
    logic        mirror_en, irq;
    logic [1:0]  r;
    int          errors = 0;
    int          num_checks = 0;
    int          c;

    always #20 aclk = ~aclk;

    fast_link_drop_config #(.MS_CYCLES(MSC)) u_fast_link_drop_config (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .drop_criteria(drop_criteria), .energy_accum(energy_accum),
        .signal_detect(signal_detect), .strap_rx_mode(strap_rx_mode),
        .strap_qd_en(strap_qd_en), .strap_mirror(strap_mirror),
        .robust_xover_en(robust_xover_en),
        .xover_timer_code(xover_timer_code),
        .xover_timer_tick(xover_timer_tick), .partner_drop(partner_drop),
        .quick_drop_link(quick_drop_link), .energy_low(energy_low),
        .internal_test_mode_one(internal_test_mode_one),
        .mirror_en(mirror_en), .irq(irq));

    link_partner u_link_partner (
        .aclk(aclk), .crit_cmd(crit_cmd), .level_cmd(level_cmd),
        .tx_cmd(tx_cmd), .crit(drop_criteria), .level(energy_accum),
        .sig(signal_detect));

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic timeout();
        errors++;
        final_report();
    endtask

    task automatic wr(input logic [6:0] i, input logic [15:0] v,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= {3'h0, i, 2'h0};
        wdata <= {16'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        r = 2'h3;
        while (n < 40 && r === 2'h3) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
            end
        end
        if (r === 2'h3) timeout();
        `CHK("bresp", er, r)
    endtask

    task automatic rd(input logic [6:0] i);
        int n;
        @(posedge aclk);
        araddr <= {3'h0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        r = 2'h3;
        while (n < 40 && r === 2'h3) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        if (r === 2'h3) timeout();
    endtask

    task automatic rdchk(input logic [6:0] i, input logic [15:0] e);
        rd(i);
        `CHK("rresp", `RESP_OKAY, r)
        `CHK("rdata", {16'h0, e}, d)
    endtask

    task automatic rst(input logic [1:0] m);
        @(posedge aclk);
        aresetn <= 1'b0;
        strap_rx_mode <= m;
        strap_mirror <= m[0];
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    // returns how many cycles the drop pulse stood
    task automatic pulse(input src_vec_t b);
        @(posedge aclk);
        crit_cmd <= b;
        @(posedge aclk);
        crit_cmd <= '0;
        c = 0;
        repeat (6) begin
            @(posedge aclk);
            if (quick_drop_link === 1'b1) c++;
        end
    endtask

    // cycles between two timer pulses
    task automatic per();
        c = 0;
        while (xover_timer_tick !== 1'b1 && c < 400) begin
            @(posedge aclk);
            c++;
        end
        if (xover_timer_tick !== 1'b1) timeout();
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (xover_timer_tick !== 1'b1 && c < 400);
        if (xover_timer_tick !== 1'b1) timeout();
    endtask

    task automatic t_reset();
        rdchk(`IDX_XOVER_TMR, 16'h141f);
        rdchk(`IDX_DROP_CFG, 16'h0000);
        rdchk(`IDX_DROP_THR, 16'h0221);
        rdchk(`IDX_CFG_FOUR, 16'h1091);
        `CHK("itm", 1'b1, internal_test_mode_one)
        rd(`IDX_STRAP_STS);
        `CHK("strap_sts", 1'b0, d[`BIT_STRAP_TM])
        rd(`IDX_XOVER_CTRL);
        `CHK("robust", 1'b0, d[`BIT_ROBUST_EN])
        rd(`IDX_NONE);
        `CHK("rresp", `RESP_SLVERR, r)
        wr(`IDX_NONE, 16'h1234, `RESP_SLVERR);
    endtask

    task automatic t_test_mode();
        wr(`IDX_CFG_FOUR, 16'h0000, `RESP_OKAY);
        rdchk(`IDX_CFG_FOUR, 16'h1010);
        repeat (2) @(posedge aclk);
        `CHK("itm", 1'b0, internal_test_mode_one)
        `CHK("mirror", 1'b0, mirror_en)
    endtask

    task automatic t_sources();
        for (int i = 0; i < 5; i++) begin
            wr(`IDX_DROP_CFG, 16'h4000 | (16'h1 << i), `RESP_OKAY);
            pulse(5'h1f);
            `CHK("drop_pulses", 1, c)
            rdchk(`IDX_DROP_CFG, 16'h4000 | (16'h101 << i));
            rdchk(`IDX_DROP_CFG, 16'h4000 | (16'h1 << i));
        end
        wr(`IDX_DROP_CFG, 16'h001f, `RESP_OKAY);
        pulse(5'h1f);
        `CHK("drop_pulses", 0, c)
    endtask

    task automatic t_irq();
        wr(`IDX_INT_CLR, 16'h001f, `RESP_OKAY);
        wr(`IDX_INT_EN, 16'h0008, `RESP_OKAY);
        wr(`IDX_DROP_CFG, 16'h4008, `RESP_OKAY);
        pulse(5'h08);
        `CHK("irq", 1'b1, irq)
        rdchk(`IDX_INT_STS, 16'h0008);
        wr(`IDX_INT_CLR, 16'h0008, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        wr(`IDX_INT_EN, 16'h0000, `RESP_OKAY);
        pulse(5'h08);
        `CHK("irq", 1'b0, irq)
        rdchk(`IDX_INT_STS, 16'h0008);
        rdchk(`IDX_INT_CLR, 16'h0000);
    endtask

    task automatic t_line();
        level_cmd <= 8'h00;
        repeat (4) @(posedge aclk);
        `CHK("energy_low", 1'b1, energy_low)
        level_cmd <= 8'h01;
        repeat (4) @(posedge aclk);
        `CHK("energy_low", 1'b0, energy_low)
        wr(`IDX_DROP_THR, 16'h0223, `RESP_OKAY);
        level_cmd <= 8'h02;
        repeat (4) @(posedge aclk);
        `CHK("energy_low", 1'b1, energy_low)
        wr(`IDX_DROP_THR, 16'h0221, `RESP_OKAY);
        level_cmd <= 8'hff;
        wr(`IDX_DROP_CFG, 16'h8000, `RESP_OKAY);
        tx_cmd <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK("partner_drop", 1'b1, partner_drop)
        tx_cmd <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK("partner_drop", 1'b0, partner_drop)
    endtask

    task automatic t_timer();
        wr(`IDX_XOVER_TMR, 16'h1410, `RESP_OKAY);
        wr(`IDX_XOVER_CTRL, 16'h0200, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK("robust_en", 1'b1, robust_xover_en)
        `CHK("code", 4'h0, xover_timer_code)
        per();
        `CHK("period", 32 * MSC, c)
        wr(`IDX_XOVER_TMR, 16'h1411, `RESP_OKAY);
        per();
        per();
        `CHK("period", 2 * 32 * MSC, c)
    endtask

    task automatic t_straps();
        strap_qd_en <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            rst(m[1:0]);
            `CHK("itm", m == 1 || m == 2, internal_test_mode_one)
            `CHK("mirror", m[0], mirror_en)
        end
        rdchk(`IDX_DROP_THR, 16'h0222);
        rdchk(`IDX_DROP_CFG, 16'h4000);
        rd(`IDX_STRAP_STS);
        `CHK("strap_sts", 1'b1, d[`BIT_STRAP_TM])
        wr(`IDX_DROP_THR, 16'h0221, `RESP_OKAY);
        rdchk(`IDX_DROP_THR, 16'h0221);
        // upper lane only: threshold byte must survive
        wstrb <= 4'h2;
        wr(`IDX_DROP_THR, 16'h0005, `RESP_OKAY);
        wstrb <= 4'hf;
        rdchk(`IDX_DROP_THR, 16'h0021);
    endtask

    initial begin
        rst(2'h1);
        t_reset();
        t_test_mode();
        t_sources();
        t_irq();
        t_line();
        t_timer();
        t_straps();
        final_report();
    end
endmodule
